// ---- period_match_timer_pkg.sv ----
// package: register map, field layout and reset values of the period match timer
// How it works
// - the block holds an eight-bit tick counter and an eight-bit period limit, both read/write.
// - a match event occurs on a count tick while the tick counter equals the period limit.
// - the counter advances on clk/4 ticks through a prescaler of 1, 4 or 16 chosen by control bits 1:0.
// - matches pass a four-bit postscaler so only every Nth match, N 1 to 16, sets the flag.
// - postscale select in control bits 6:3 gives a ratio of field value plus one.
// - control bit 2 is the run bit; counting stops while it is zero.
// - the tick counter clears to zero on every reset.
// - prescale and postscale counts clear on a write to the tick counter, a control write or reset.
// - a control write leaves the tick counter value unchanged.
// - the postscaled match is latched in a flag and raises the interrupt only while enabled.
// - control bit 7 reads as zero and all other control bits reset to zero.
// - the period match is offered as a PWM time base pulse.
package period_match_timer_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_TICK = 8'h00;
  localparam logic [7:0] OFS_LIMIT = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_CLEAR = 8'h10;
  localparam logic [7:0] OFS_ENABLE = 8'h14;
  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int PRE_LSB = 0;
  localparam int RUN_BIT = 2;
  localparam int POST_LSB = 3;
  localparam int POST_MSB = 6;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [7:0] TICK_RESET = 8'h00;
  localparam logic [7:0] LIMIT_RESET = 8'hFF;
  // instruction clock is the system clock divided by four
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam logic [3:0] PRE_LAST_1 = 4'h0;
  localparam logic [3:0] PRE_LAST_4 = 4'h3;
  localparam logic [3:0] PRE_LAST_16 = 4'hF;
endpackage

// ---- tick_prescaler.sv ----
// module: instruction-clock divider and selectable prescaler producing count ticks
`timescale 1ns/10ps
module tick_prescaler (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, high
  input wire logic clear, // clears both dividers
  input wire logic run, // run bit
  input wire logic [1:0] preSel, // prescale select
  output logic tick // one-cycle count tick
);
  typedef struct packed {
    logic [1:0] quarter;
    logic [3:0] pre;
  } pre_s;
  pre_s state_ff;
  pre_s nxt_state;
  logic [3:0] preLast;

  always_comb begin
    case (preSel)
      2'h0: preLast = period_match_timer_pkg::PRE_LAST_1;
      2'h1: preLast = period_match_timer_pkg::PRE_LAST_4;
      default: preLast = period_match_timer_pkg::PRE_LAST_16;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    tick = 1'b0;
    if (clear) begin
      nxt_state = '0;
    end else if (run) begin
      nxt_state.quarter = state_ff.quarter + 2'h1;
      if (state_ff.quarter == period_match_timer_pkg::INSTR_DIV_LAST) begin
        if (state_ff.pre >= preLast) begin
          nxt_state.pre = 4'h0;
          tick = 1'b1;
        end else begin
          nxt_state.pre = state_ff.pre + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule

// ---- period_match_timer.sv ----
// module: eight-bit period match timer with postscaler, interrupt and APB registers
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/10ps
module period_match_timer (
  input wire logic clk_sys, // system clock, 10 MHz
  input wire logic rst, // async reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic irq, // level interrupt
  output logic timeBase // one-cycle period match pulse
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] tickCount;
    logic [7:0] periodLimit;
    logic [6:0] timerControl;
    logic [3:0] postCount;
    logic matchEventFlag;
    logic matchEventIrqEnable;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic irq;
    logic timeBase;
  } timer_s;
  timer_s st_ff;
  timer_s nxt_st;
  logic tick;
  logic isMatch;
  logic postHit;
  logic acc;
  logic wrTick;
  logic wrCtrl;
  logic runOn;
  logic clrPre;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == period_match_timer_pkg::OFS_TICK) || (a == period_match_timer_pkg::OFS_LIMIT)
      || (a == period_match_timer_pkg::OFS_CTRL) || (a == period_match_timer_pkg::OFS_STATUS)
      || (a == period_match_timer_pkg::OFS_CLEAR) || (a == period_match_timer_pkg::OFS_ENABLE);
  endfunction

  // access phase, one wait state: answer comes in the cycle after penable rises
  assign acc = psel && penable && !st_ff.ready;
  assign wrTick = acc && pwrite && (paddr == period_match_timer_pkg::OFS_TICK);
  assign wrCtrl = acc && pwrite && (paddr == period_match_timer_pkg::OFS_CTRL);
  assign runOn = st_ff.timerControl[period_match_timer_pkg::RUN_BIT];
  assign clrPre = wrTick || wrCtrl;
  assign isMatch = (st_ff.tickCount == st_ff.periodLimit);
  // postscaler counts only on the tick that ends a period
  assign postHit = tick && isMatch
    && (st_ff.postCount == st_ff.timerControl[period_match_timer_pkg::POST_MSB:
        period_match_timer_pkg::POST_LSB]);

  tick_prescaler u_pre (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(clrPre),
    .run(runOn),
    .preSel(st_ff.timerControl[1:0]),
    .tick(tick)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ready = 1'b0;
    nxt_st.err = 1'b0;
    nxt_st.timeBase = tick && isMatch;
    if (tick) begin
      if (isMatch) begin
        nxt_st.tickCount = 8'h00;
        nxt_st.postCount = postHit ? 4'h0 : st_ff.postCount + 4'h1;
      end else begin
        nxt_st.tickCount = st_ff.tickCount + 8'h01;
      end
    end
    if (wrTick || wrCtrl) begin
      nxt_st.postCount = 4'h0;
    end
    if (acc) begin
      nxt_st.ready = 1'b1;
      nxt_st.err = !mapped(paddr);
      nxt_st.rdata = 32'h0000_0000;
      if (pwrite) begin
        case (paddr)
          period_match_timer_pkg::OFS_TICK: nxt_st.tickCount = pwdata[7:0];
          period_match_timer_pkg::OFS_LIMIT: nxt_st.periodLimit = pwdata[7:0];
          period_match_timer_pkg::OFS_CTRL: nxt_st.timerControl = pwdata[6:0];
          period_match_timer_pkg::OFS_ENABLE: nxt_st.matchEventIrqEnable = pwdata[0];
          period_match_timer_pkg::OFS_CLEAR: begin
            if (pwdata[0]) begin
              nxt_st.matchEventFlag = 1'b0;
            end
          end
          default: nxt_st.rdata = 32'h0000_0000;
        endcase
      end else begin
        case (paddr)
          period_match_timer_pkg::OFS_TICK: nxt_st.rdata = {24'h000000, st_ff.tickCount};
          period_match_timer_pkg::OFS_LIMIT: nxt_st.rdata = {24'h000000, st_ff.periodLimit};
          period_match_timer_pkg::OFS_CTRL: nxt_st.rdata = {25'h0, st_ff.timerControl};
          period_match_timer_pkg::OFS_STATUS: nxt_st.rdata = {31'h0, st_ff.matchEventFlag};
          period_match_timer_pkg::OFS_ENABLE: nxt_st.rdata = {31'h0, st_ff.matchEventIrqEnable};
          default: nxt_st.rdata = 32'h0000_0000;
        endcase
      end
    end
    // set after clear so a same-cycle event is not lost
    if (postHit) begin
      nxt_st.matchEventFlag = 1'b1;
    end
    nxt_st.irq = nxt_st.matchEventFlag && nxt_st.matchEventIrqEnable;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.tickCount <= period_match_timer_pkg::TICK_RESET;
      st_ff.periodLimit <= period_match_timer_pkg::LIMIT_RESET;
      st_ff.timerControl <= period_match_timer_pkg::CTRL_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.err;
  assign irq = st_ff.irq;
  assign timeBase = st_ff.timeBase;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // counter
  // ----------------------------------------
  a_tick_wrap: assert property (
    tick && isMatch && !wrTick && !acc
    |=> st_ff.tickCount == 8'h00)
    else $error("counter did not wrap at limit");

  a_tick_inc: assert property (
    tick && !isMatch && !acc
    |=> st_ff.tickCount == $past(st_ff.tickCount) + 8'h01)
    else $error("counter did not increment");

  a_stop_hold: assert property (
    !st_ff.timerControl[2] && !acc
    |=> $stable(st_ff.tickCount))
    else $error("counter moved while stopped");

  a_run_gate: assert property (
    !runOn
    |-> !tick)
    else $error("tick while run bit clear");

  a_ctrl_keep: assert property (
    wrCtrl && !tick
    |=> st_ff.tickCount == $past(st_ff.tickCount))
    else $error("control write changed counter");

  a_tick_write: assert property (
    wrTick
    |=> st_ff.tickCount == $past(pwdata[7:0]))
    else $error("counter write lost");

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  a_tick_gap: assert property (
    tick
    |=> !tick [*3])
    else $error("ticks closer than four clocks");

  a_pre1_rate: assert property (
    tick && st_ff.timerControl[1:0] == 2'h0 ##1 (runOn && !clrPre) [*4]
    |-> tick)
    else $error("prescale one tick missing");

  a_pre_restart: assert property (
    clrPre
    |=> !tick [*3])
    else $error("prescaler not restarted");

  a_clear_stops: assert property (
    clrPre
    |-> !tick)
    else $error("tick during prescaler clear");

  // ----------------------------------------
  // postscaler, flag and interrupt
  // ----------------------------------------
  a_post_clear: assert property (
    wrTick || wrCtrl
    |=> st_ff.postCount == 4'h0)
    else $error("postscaler not cleared");

  a_post_step: assert property (
    tick && isMatch && !postHit && !clrPre
    |=> st_ff.postCount == $past(st_ff.postCount) + 4'h1)
    else $error("postscaler did not advance");

  a_post_hold: assert property (
    !(tick && isMatch) && !clrPre
    |=> $stable(st_ff.postCount))
    else $error("postscaler moved without match");

  a_post_wrap: assert property (
    postHit
    |=> st_ff.postCount == 4'h0)
    else $error("postscaler did not restart");

  a_flag_set: assert property (
    postHit
    |=> st_ff.matchEventFlag)
    else $error("flag not set on postscaled match");

  a_flag_rise: assert property (
    $rose(st_ff.matchEventFlag)
    |-> $past(postHit))
    else $error("flag set without postscaled match");

  a_flag_clear: assert property (
    acc && pwrite && paddr == period_match_timer_pkg::OFS_CLEAR && pwdata[0] && !postHit
    |=> !st_ff.matchEventFlag)
    else $error("flag not cleared");

  a_flag_hold: assert property (
    st_ff.matchEventFlag && !acc
    |=> st_ff.matchEventFlag)
    else $error("flag dropped without clear");

  a_irq_gate: assert property (
    1'b1
    |-> irq == (st_ff.matchEventFlag && st_ff.matchEventIrqEnable))
    else $error("interrupt not gated by enable");

  a_irq_enable: assert property (
    irq
    |-> st_ff.matchEventIrqEnable)
    else $error("interrupt while disabled");

  a_irq_flag: assert property (
    irq
    |-> st_ff.matchEventFlag)
    else $error("interrupt without flag");

  // ----------------------------------------
  // registers and bus
  // ----------------------------------------
  a_limit_write: assert property (
    acc && pwrite && paddr == period_match_timer_pkg::OFS_LIMIT
    |=> st_ff.periodLimit == $past(pwdata[7:0]))
    else $error("limit write lost");

  a_ctrl_write: assert property (
    wrCtrl
    |=> st_ff.timerControl == $past(pwdata[6:0]))
    else $error("control write lost");

  a_tick_read: assert property (
    acc && !pwrite && paddr == period_match_timer_pkg::OFS_TICK
    |=> prdata == {24'h000000, $past(st_ff.tickCount)})
    else $error("counter read wrong");

  a_limit_read: assert property (
    acc && !pwrite && paddr == period_match_timer_pkg::OFS_LIMIT
    |=> prdata == {24'h000000, $past(st_ff.periodLimit)})
    else $error("limit read wrong");

  a_status_read: assert property (
    acc && !pwrite && paddr == period_match_timer_pkg::OFS_STATUS
    |=> prdata == {31'h00000000, $past(st_ff.matchEventFlag)})
    else $error("status read wrong");

  a_ctrl_b7: assert property (
    pready && $past(paddr) == period_match_timer_pkg::OFS_CTRL && !$past(pwrite)
    |-> prdata[31:7] == '0)
    else $error("control bit 7 not zero");

  a_ready_pulse: assert property (
    pready
    |=> !pready)
    else $error("ready longer than one cycle");

  a_ready_answer: assert property (
    psel && penable && !pready
    |=> pready)
    else $error("access not answered");

  a_err_unmapped: assert property (
    acc && !mapped(paddr)
    |=> pslverr)
    else $error("unmapped access not refused");

  a_err_mapped: assert property (
    acc && mapped(paddr)
    |=> !pslverr)
    else $error("mapped access refused");

  a_unmapped_data: assert property (
    acc && !mapped(paddr)
    |=> prdata == 32'h00000000)
    else $error("unmapped read not zero");

  // ----------------------------------------
  // time base
  // ----------------------------------------
  a_match_pulse: assert property (
    tick && isMatch
    |=> timeBase ##1 !timeBase)
    else $error("time base pulse wrong");

  a_base_cause: assert property (
    timeBase
    |-> $past(tick && isMatch))
    else $error("time base without match");

  a_base_run: assert property (
    timeBase
    |-> $past(runOn))
    else $error("time base while stopped");

  // ----------------------------------------
  // coverage
  // ----------------------------------------
  c_wrap: cover property (tick && isMatch);
  c_irq: cover property (irq);
  c_post16: cover property (postHit && st_ff.timerControl[6:3] == 4'hF);
  c_pre16: cover property (tick && st_ff.timerControl[1]);
  c_clear: cover property (acc && pwrite && paddr == period_match_timer_pkg::OFS_CLEAR);
endmodule

// ---- period_match_timer_tb_top.sv ----
// testbench: apb register, period, postscale and interrupt checks of the period match timer
`timescale 1ns/10ps
module period_match_timer_tb_top;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq, timeBase, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  int nErrors = 0, checks = 0, cycles = 0, n, k, pre;
  int posts [3] = '{0, 3, 15};
  period_match_timer dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .timeBase(timeBase));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task test_done;
    $display("comparisons %0d mismatches %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard, tests need well under this
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      nErrors++;
      $display("[FAIL] %0t timeout", $time);
      test_done();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // ----------------------------------------
  // apb master
  // ----------------------------------------
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // only the bench timeout ends this wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdData = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
    chk({31'h00000000, err}, 32'h00000000, "write error");
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h00000000);
    chk({31'h00000000, err}, 32'h00000000, "read error");
    chk(rdData, {24'h000000, e}, "read data");
  endtask
  // cycles up to and including the next time base pulse
  task pulse(output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (timeBase !== 1'b1 && c < 2000);
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(period_match_timer_pkg::OFS_TICK, 8'h00);
    rd(period_match_timer_pkg::OFS_LIMIT, period_match_timer_pkg::LIMIT_RESET);
    rd(period_match_timer_pkg::OFS_CTRL, 8'h00);
    rd(period_match_timer_pkg::OFS_STATUS, 8'h00);
    wr(period_match_timer_pkg::OFS_CTRL, 8'hFF);
    rd(period_match_timer_pkg::OFS_CTRL, 8'h7F);
    apb(1'b0, 8'h18, 32'h00000000);
    chk({31'h00000000, err}, 32'h00000001, "unmapped error");
    chk(rdData, 32'h00000000, "unmapped data");
    $display("test reset and map done");
    // every prescale code, period of 4*P*(limit+1) clocks
    for (int p = 0; p < 4; p++) begin
      pre = (p == 0) ? 1 : (p == 1) ? 4 : 16;
      wr(period_match_timer_pkg::OFS_LIMIT, 8'h02);
      rd(period_match_timer_pkg::OFS_LIMIT, 8'h02);
      wr(period_match_timer_pkg::OFS_TICK, 8'h00);
      wr(period_match_timer_pkg::OFS_CTRL, 8'h04 | 8'(p));
      pulse(n);
      pulse(n);
      chk(32'(n), 32'(4 * pre * 3), "period clocks");
    end
    $display("test prescale done");
    // flag after post+1 matches, irq only while enabled
    foreach (posts[i]) begin
      k = posts[i];
      wr(period_match_timer_pkg::OFS_CTRL, 8'(k << 3));
      wr(period_match_timer_pkg::OFS_CLEAR, 8'h01);
      wr(period_match_timer_pkg::OFS_ENABLE, 8'h01);
      wr(period_match_timer_pkg::OFS_LIMIT, 8'h01);
      wr(period_match_timer_pkg::OFS_TICK, 8'h00);
      wr(period_match_timer_pkg::OFS_CTRL, 8'(k << 3) | 8'h04);
      n = 0;
      pre = 0;
      while (irq !== 1'b1 && pre < 1000) begin
        @(posedge clk_sys);
        pre++;
        if (timeBase === 1'b1) n++;
      end
      chk(32'(n), 32'(k + 1), "matches to flag");
    end
    wr(period_match_timer_pkg::OFS_CTRL, 8'h00);
    wr(period_match_timer_pkg::OFS_ENABLE, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk({31'h00000000, irq}, 32'h00000000, "masked irq");
    rd(period_match_timer_pkg::OFS_STATUS, 8'h01);
    wr(period_match_timer_pkg::OFS_CLEAR, 8'h01);
    rd(period_match_timer_pkg::OFS_STATUS, 8'h00);
    $display("test postscale and irq done");
    // stopped counter holds, control write keeps count
    wr(period_match_timer_pkg::OFS_TICK, 8'h05);
    repeat (40) @(posedge clk_sys);
    rd(period_match_timer_pkg::OFS_TICK, 8'h05);
    wr(period_match_timer_pkg::OFS_CTRL, 8'h7B);
    rd(period_match_timer_pkg::OFS_TICK, 8'h05);
    rd(period_match_timer_pkg::OFS_CTRL, 8'h7B);
    $display("test run bit done");
    // reset while running clears counter and control; flag, never set here, reads zero
    wr(period_match_timer_pkg::OFS_CTRL, 8'h04);
    repeat (30) @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(period_match_timer_pkg::OFS_TICK, 8'h00);
    rd(period_match_timer_pkg::OFS_CTRL, 8'h00);
    rd(period_match_timer_pkg::OFS_STATUS, 8'h00);
    $display("test mid-run reset done");
    test_done();
  end
endmodule
